// >>> hw/cuci_pkg.sv
package cuci_pkg;

   // Opcodes
   localparam logic [7:0] OPC_COM_R = 8'h60;
   localparam logic [7:0] OPC_COM_IR = 8'h61;
   localparam logic [7:0] OPC_CMP_WW = 8'ha2;
   localparam logic [7:0] OPC_CMP_WIW = 8'ha3;
   localparam logic [7:0] OPC_CMP_RR = 8'ha4;
   localparam logic [7:0] OPC_CMP_RIR = 8'ha5;
   localparam logic [7:0] OPC_CMP_RIM = 8'ha6;
   localparam logic [7:0] OPC_DEC_R = 8'h00;
   localparam logic [7:0] OPC_DEC_IR = 8'h01;
   localparam logic [7:0] OPC_INC_R = 8'h20;
   localparam logic [7:0] OPC_INC_IR = 8'h21;
   localparam logic [7:0] OPC_GIRQ_DIS = 8'h8f;
   localparam logic [7:0] OPC_GIRQ_EN = 8'h9f;
   localparam logic [7:0] OPC_IDLE = 8'h6f;
   localparam logic [3:0] OPC_INC_W_LO = 4'he;

   localparam logic [2:0] CYC_SHORT = 3'h4;
   localparam logic [2:0] CYC_LONG = 3'h6;
   localparam logic [2:0] PH_PTR = 3'h1;
   localparam logic [2:0] PH_OPND = 3'h2;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

   // Flag register layout
   localparam int FLG_C = 7;
   localparam int FLG_Z = 6;
   localparam int FLG_S = 5;
   localparam int FLG_V = 4;
   localparam int SIGN_BIT = 7;
   localparam int GIE_BIT = 2;
   localparam logic [7:0] BYTE_MIN_NEG = 8'h80;
   localparam logic [7:0] BYTE_MAX_POS = 8'h7f;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] SYM_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;

   // Register map (byte addresses)
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_INSTR = 12'h000;
   localparam logic [11:0] ADDR_FLAGS = 12'h004;
   localparam logic [11:0] ADDR_SYM = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00c;
   localparam logic [11:0] ADDR_PEND = 12'h010;
   localparam logic [1:0] RF_REGION = 2'h1;
   localparam int RF_DEPTH = 256;
   localparam int IRQ_N = 8;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      OP_COM, OP_CMP, OP_DEC, OP_INC, OP_GDIS, OP_GEN, OP_IDLE, OP_BAD
   } cuci_op_type;

   typedef struct packed {
      cuci_op_type op;
      logic [7:0] dst;
      logic dst_ind;
      logic [7:0] src;
      logic src_ind;
      logic src_imm;
      logic [1:0] len;
      logic [2:0] cyc;
   } cuci_dec_type;

   function automatic cuci_dec_type cuci_decode(input logic [7:0] opc, input logic [7:0] b2,
                                                input logic [7:0] b3);
      cuci_dec_type d;
      d = '0;
      d.op = OP_BAD;
      d.len = LEN_TWO;
      d.cyc = CYC_SHORT;
      d.dst = b2;
      if (opc[3:0] == OPC_INC_W_LO) begin
         d.op = OP_INC;
         d.dst = {4'h0, opc[7:4]};
         d.len = LEN_ONE;
      end
      case (opc)
         OPC_COM_R, OPC_COM_IR: begin
            d.op = OP_COM;
            d.dst_ind = opc[0];
         end
         OPC_DEC_R, OPC_DEC_IR: begin
            d.op = OP_DEC;
            d.dst_ind = opc[0];
         end
         OPC_INC_R, OPC_INC_IR: begin
            d.op = OP_INC;
            d.dst_ind = opc[0];
         end
         OPC_CMP_WW, OPC_CMP_WIW: begin
            d.op = OP_CMP;
            d.dst = {4'h0, b2[7:4]};
            d.src = {4'h0, b2[3:0]};
            d.src_ind = (opc == OPC_CMP_WIW);
            d.cyc = (opc == OPC_CMP_WIW) ? CYC_LONG : CYC_SHORT;
         end
         OPC_CMP_RR, OPC_CMP_RIR: begin
            d.op = OP_CMP;
            d.src = b2;
            d.dst = b3;
            d.src_ind = (opc == OPC_CMP_RIR);
            d.len = LEN_THREE;
            d.cyc = CYC_LONG;
         end
         OPC_CMP_RIM: begin
            d.op = OP_CMP;
            d.src = b3;
            d.src_imm = 1'b1;
            d.len = LEN_THREE;
            d.cyc = CYC_LONG;
         end
         OPC_GIRQ_DIS: begin
            d.op = OP_GDIS;
            d.len = LEN_ONE;
         end
         OPC_GIRQ_EN: begin
            d.op = OP_GEN;
            d.len = LEN_ONE;
         end
         OPC_IDLE: begin
            d.op = OP_IDLE;
            d.len = LEN_ONE;
         end
         default: begin
         end
      endcase
      return d;
   endfunction

endpackage

// >>> hw/cuci_if.sv
`timescale 1ns/1ps
interface cuci_alu_if;
   import cuci_pkg::*;
   cuci_op_type op;
   logic [7:0] dst;
   logic [7:0] src;
   logic [7:0] flags_in;
   logic [7:0] res;
   logic [7:0] flags_out;
   logic wr_dst;
   modport engine (output op, dst, src, flags_in, input res, flags_out, wr_dst);
   modport alu (input op, dst, src, flags_in, output res, flags_out, wr_dst);
endinterface

interface cuci_rf_if;
   logic [7:0] ra;
   logic [7:0] rb;
   logic [7:0] rc;
   logic [7:0] qa;
   logic [7:0] qb;
   logic [7:0] qc;
   logic we;
   logic [7:0] wa;
   logic [7:0] wd;
   modport user (output ra, rb, rc, we, wa, wd, input qa, qb, qc);
   modport store (input ra, rb, rc, we, wa, wd, output qa, qb, qc);
endinterface

// >>> hw/cuci_alu.sv
`timescale 1ns/1ps
module cuci_alu
   import cuci_pkg::*;
(
   cuci_alu_if.alu a
);

   logic [8:0] diff;
   logic [7:0] v;

   always_comb begin
      diff = {1'b0, a.dst} - {1'b0, a.src};
      a.res = a.dst;
      a.flags_out = a.flags_in;
      a.wr_dst = 1'b0;
      v = a.dst;
      case (a.op)
         OP_COM: begin
            a.res = ~a.dst;
            a.wr_dst = 1'b1;
            a.flags_out[FLG_V] = 1'b0;
         end
         OP_CMP: begin
            a.flags_out[FLG_C] = diff[8];
            a.flags_out[FLG_V] = (a.dst[SIGN_BIT] != a.src[SIGN_BIT]) &&
                                 (diff[SIGN_BIT] == a.src[SIGN_BIT]);
         end
         OP_DEC: begin
            a.res = a.dst - BYTE_ONE;
            a.wr_dst = 1'b1;
            a.flags_out[FLG_V] = (a.dst == BYTE_MIN_NEG) && (a.res == BYTE_MAX_POS);
         end
         OP_INC: begin
            a.res = a.dst + BYTE_ONE;
            a.wr_dst = 1'b1;
            a.flags_out[FLG_V] = (a.dst == BYTE_MAX_POS) && (a.res == BYTE_MIN_NEG);
         end
         default: begin
         end
      endcase
      // Compare never writes back, only the difference feeds the flags
      v = (a.op == OP_CMP) ? diff[7:0] : a.res;
      if (a.op == OP_COM || a.op == OP_CMP || a.op == OP_DEC || a.op == OP_INC) begin
         a.flags_out[FLG_Z] = (v == 8'h00);
         a.flags_out[FLG_S] = v[SIGN_BIT];
      end
   end

endmodule // cuci_alu

// >>> hw/cuci_regfile.sv
`timescale 1ns/1ps
module cuci_regfile
   import cuci_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   cuci_rf_if.store r
);

   typedef struct packed {
      logic [RF_DEPTH-1:0][7:0] mem;
   } cuci_rf_state_type;

   cuci_rf_state_type q;
   cuci_rf_state_type d;

   assign r.qa = q.mem[r.ra];
   assign r.qb = q.mem[r.rb];
   assign r.qc = q.mem[r.rc];

   always_comb begin
      d = q;
      if (r.we) begin
         d.mem[r.wa] = r.wd;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule // cuci_regfile

// >>> hw/cuci_core.sv
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cuci_core
   import cuci_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [IRQ_N-1:0] irq_req_i,
   output logic cpu_clk_en_o,
   output logic busy_o,
   output logic irq_ack_o,
   output logic [2:0] irq_vec_o
);

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_have;
      logic [11:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [23:0] instr;
      cuci_dec_type dec;
      logic busy;
      logic [2:0] ph;
      logic [7:0] dst_addr;
      logic [7:0] src_addr;
      logic [7:0] dst_val;
      logic [7:0] src_val;
      logic [7:0] flags;
      logic [7:0] system_mode_reg;
      logic [IRQ_N-1:0] pend;
      logic idle;
      logic clk_en;
      logic bad;
      logic [15:0] pc;
      logic ack;
      logic [2:0] vec;
   } cuci_core_state_type;

   cuci_core_state_type q;
   cuci_core_state_type d;

   cuci_alu_if alu_bus ();
   cuci_rf_if rf_bus ();

   cuci_alu u_alu (
      .a(alu_bus.alu)
   );

   cuci_regfile u_rf (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .r(rf_bus.store)
   );

   // Byte-lane merge of a bus write into an existing word
   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // Lowest set pending bit wins service
   function automatic logic [2:0] lowest_set(input logic [IRQ_N-1:0] p);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (p[i]) begin
            idx = i[2:0];
         end
      end
      return idx;
   endfunction

   logic [IRQ_N-1:0] pend_clr;
   logic [31:0] merged;
   logic locked;

   always_comb begin
      d = q;
      pend_clr = '0;
      merged = 32'h0;
      d.ack = 1'b0;
      // Bus updates of instruction, flags and register file are refused while it runs or sleeps
      locked = q.busy || q.idle;
      alu_bus.op = q.dec.op;
      alu_bus.dst = q.dst_val;
      alu_bus.src = q.src_val;
      alu_bus.flags_in = q.flags;
      rf_bus.ra = (q.ph == PH_PTR) ? q.dec.dst : q.dst_addr;
      rf_bus.rb = (q.ph == PH_PTR) ? q.dec.src : q.src_addr;
      rf_bus.rc = s_axi_araddr[9:2];
      rf_bus.we = 1'b0;
      rf_bus.wa = 8'h00;
      rf_bus.wd = 8'h00;

      // Write address and data are taken independently, in either order
      if (q.awready && s_axi_awvalid) begin
         d.aw_have = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (q.wready && s_axi_wvalid) begin
         d.w_have = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (q.aw_addr)
            ADDR_INSTR: begin
               if (locked) begin
                  d.bresp = RESP_SLVERR;
               end else begin
                  merged = strb_merge({8'h00, q.instr}, q.w_data, q.w_strb);
                  d.instr = merged[23:0];
                  d.dec = cuci_decode(merged[7:0], merged[15:8], merged[23:16]);
                  d.bad = (d.dec.op == OP_BAD);
                  d.busy = (d.dec.op != OP_BAD);
                  d.ph = PH_PTR;
               end
            end
            ADDR_FLAGS: begin
               if (locked) begin
                  d.bresp = RESP_SLVERR;
               end else begin
                  merged = strb_merge({24'h0, q.flags}, q.w_data, q.w_strb);
                  d.flags = merged[7:0];
               end
            end
            ADDR_SYM: begin
               merged = strb_merge({24'h0, q.system_mode_reg}, q.w_data, q.w_strb);
               d.system_mode_reg = merged[7:0];
            end
            ADDR_PEND: begin
               if (q.w_strb[0]) begin
                  pend_clr = q.w_data[IRQ_N-1:0];
               end
            end
            default: begin
               if (q.aw_addr[11:10] != RF_REGION || locked) begin
                  d.bresp = RESP_SLVERR;
               end else if (q.w_strb[0]) begin
                  rf_bus.we = 1'b1;
                  rf_bus.wa = q.aw_addr[9:2];
                  rf_bus.wd = q.w_data[7:0];
               end
            end
         endcase
      end

      if (q.arready && s_axi_arvalid) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_INSTR: d.rdata = {8'h00, q.instr};
            ADDR_FLAGS: d.rdata = {24'h0, q.flags};
            ADDR_SYM: d.rdata = {24'h0, q.system_mode_reg};
            ADDR_STATUS: d.rdata = {q.pc, 13'h0, q.bad, q.idle, q.busy};
            ADDR_PEND: d.rdata = {24'h0, q.pend};
            default: begin
               if (s_axi_araddr[11:10] == RF_REGION) begin
                  d.rdata = {24'h0, rf_bus.qc};
               end else begin
                  d.rdata = 32'h0;
                  d.rresp = RESP_SLVERR;
               end
            end
         endcase
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end

      // Execution: pointer fetch, operand fetch, then commit on the last cycle
      if (q.busy) begin
         d.ph = q.ph + 3'h1;
         if (q.ph == PH_PTR) begin
            d.dst_addr = q.dec.dst_ind ? rf_bus.qa : q.dec.dst;
            d.src_addr = q.dec.src_ind ? rf_bus.qb : q.dec.src;
         end
         if (q.ph == PH_OPND) begin
            d.dst_val = rf_bus.qa;
            d.src_val = q.dec.src_imm ? q.dec.src : rf_bus.qb;
         end
         if (q.ph == q.dec.cyc) begin
            d.busy = 1'b0;
            d.pc = q.pc + {14'h0, q.dec.len};
            case (q.dec.op)
               OP_GDIS: d.system_mode_reg[GIE_BIT] = 1'b0;
               OP_GEN: d.system_mode_reg[GIE_BIT] = 1'b1;
               OP_IDLE: d.idle = 1'b1;
               default: begin
                  d.flags = alu_bus.flags_out;
                  if (alu_bus.wr_dst) begin
                     rf_bus.we = 1'b1;
                     rf_bus.wa = q.dst_addr;
                     rf_bus.wd = alu_bus.res;
                  end
               end
            endcase
         end
      end

      // Service needs the global enable; pending bits are kept until then
      if (q.system_mode_reg[GIE_BIT] && q.pend != '0 && !q.busy && !q.idle && !q.ack) begin
         d.ack = 1'b1;
         d.vec = lowest_set(q.pend);
         pend_clr[lowest_set(q.pend)] = 1'b1;
      end
      // A request arriving with its clear is kept
      d.pend = (q.pend & ~pend_clr) | irq_req_i;
      if (q.idle && irq_req_i != '0) begin
         d.idle = 1'b0;
      end

      d.awready = !d.aw_have && !d.bvalid;
      d.wready = !d.w_have && !d.bvalid;
      d.arready = !d.rvalid;
      // Kept as its own flop so the gate enable never sees decode glitches
      d.clk_en = !d.idle;
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         q <= '0;
         q.dec.op <= OP_BAD;
         q.flags <= FLAGS_RST;
         q.system_mode_reg <= SYM_RST;
         q.pc <= PC_RST;
         q.idle <= 1'b0;
         q.clk_en <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = q.rdata;
   assign cpu_clk_en_o = q.clk_en;
   assign busy_o = q.busy;
   assign irq_ack_o = q.ack;
   assign irq_vec_o = q.vec;

endmodule // cuci_core

// >>> bench/cuci_props.sv
`timescale 1ns/1ps
module cuci_props
   import cuci_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [IRQ_N-1:0] irq_req_i,
   input wire logic cpu_clk_en_o,
   input wire logic busy_o,
   input wire logic irq_ack_o,
   input wire logic [2:0] irq_vec_o
);
   default clocking dc @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   // Only four and six cycle forms exist, so anything else is a decode slip
   busy_len_a: assert property ($rose(busy_o) |-> busy_o[*4] ##1
      (!busy_o or busy_o[*2] ##1 !busy_o)) else $error("busy length out of range");
   busy_awake_a: assert property (busy_o |-> cpu_clk_en_o)
      else $error("busy while clock gated");
   idle_entry_a: assert property ($fell(cpu_clk_en_o) |-> $fell(busy_o))
      else $error("clock gated without an instruction ending");
   wake_irq_a: assert property (!cpu_clk_en_o && (irq_req_i != '0) |=> cpu_clk_en_o)
      else $error("request did not end idle");
   idle_hold_a: assert property (!cpu_clk_en_o && (irq_req_i == '0) |=> !cpu_clk_en_o)
      else $error("idle left without a request");
   ack_gate_a: assert property (irq_ack_o |-> !$past(busy_o) && $past(cpu_clk_en_o))
      else $error("service started while busy or idle");
   ack_pulse_a: assert property (irq_ack_o |=> !irq_ack_o)
      else $error("service pulse longer than one cycle");
   vec_hold_a: assert property (!irq_ack_o |-> $stable(irq_vec_o))
      else $error("vector moved without service");
   cover property ($rose(busy_o));
   cover property (irq_ack_o);
   cover property ($fell(cpu_clk_en_o));
   cover property ($rose(cpu_clk_en_o));
endmodule // cuci_props

bind cuci_core cuci_props u_props (
   .ref_clk_i(ref_clk_i),
   .reset_i(reset_i),
   .irq_req_i(irq_req_i),
   .cpu_clk_en_o(cpu_clk_en_o),
   .busy_o(busy_o),
   .irq_ack_o(irq_ack_o),
   .irq_vec_o(irq_vec_o)
);

// >>> bench/test_cpu_unary_compare_intctl_ops.sv
`timescale 1ns/1ps
module test_cpu_unary_compare_intctl_ops
   import cuci_pkg::*;
();
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [IRQ_N-1:0] irq_req_i = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic cpu_clk_en_o, busy_o, irq_ack_o;
   logic [2:0] irq_vec_o;
   int error_cnt = 0, n_compared = 0, bcnt = 0;
   logic [2:0] vq[$];

   cuci_core dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(1'b1), .irq_req_i(irq_req_i), .cpu_clk_en_o(cpu_clk_en_o),
      .busy_o(busy_o), .irq_ack_o(irq_ack_o), .irq_vec_o(irq_vec_o)
   );

   always #25 ref_clk_i = ~ref_clk_i;

   // Counts busy samples and records every serviced vector
   always @(posedge ref_clk_i) begin
      if (busy_o) bcnt <= bcnt + 1;
      if (irq_ack_o) vq.push_back(irq_vec_o);
   end

   task automatic conclude;
      if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Ready channels are held high, so each write ends at the response edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, e);
   endtask

   function automatic logic [11:0] ra(input logic [7:0] n);
      return 12'h400 + {2'h0, n, 2'h0};
   endfunction

   task automatic sr(input logic [7:0] n, input logic [7:0] v);
      wr(ra(n), 32'(v), RESP_OKAY);
   endtask

   // Presets the flags, runs one instruction, checks its length and resulting flags
   task automatic op(input logic [23:0] ins, input int cyc, input logic [7:0] fi,
                     input logic [7:0] fe);
      int b0;
      wr(ADDR_FLAGS, 32'(fi), RESP_OKAY);
      b0 = bcnt;
      wr(ADDR_INSTR, 32'(ins), RESP_OKAY);
      while (busy_o) @(posedge ref_clk_i);
      chk(32'(bcnt - b0), 32'(cyc));
      rc(ADDR_FLAGS, 32'(fe));
   endtask

   task automatic t_com;
      sr(8'h05, 8'h07);
      op({16'h0005, OPC_COM_R}, 4, 8'h90, 8'ha0);
      rc(ra(8'h05), 32'hf8);
      sr(8'h01, 8'h07);
      sr(8'h07, 8'hf1);
      op({16'h0001, OPC_COM_IR}, 4, 8'h10, 8'h00);
      rc(ra(8'h07), 32'h0e);
      rc(ra(8'h01), 32'h07);
      sr(8'h05, 8'hff);
      op({16'h0005, OPC_COM_R}, 4, 8'h80, 8'hc0);
   endtask

   task automatic t_cmp;
      sr(8'h01, 8'h02);
      sr(8'h02, 8'h03);
      op({16'h0012, OPC_CMP_WW}, 4, 8'h00, 8'ha0);
      rc(ra(8'h01), 32'h02);
      rc(ra(8'h02), 32'h03);
      sr(8'h03, 8'h02);
      op({16'h0012, OPC_CMP_WIW}, 6, 8'hb0, 8'h40);
      sr(8'h08, 8'h80);
      sr(8'h09, 8'h01);
      op({16'h0809, OPC_CMP_RR}, 6, 8'h00, 8'h10);
      sr(8'h0a, 8'h08);
      sr(8'h0b, 8'h01);
      op({16'h0b0a, OPC_CMP_RIR}, 6, 8'h00, 8'hb0);
      op({16'h0508, OPC_CMP_RIM}, 6, 8'h80, 8'h10);
      rc(ra(8'h08), 32'h80);
      rc(ra(8'h0b), 32'h01);
   endtask

   task automatic t_dec;
      sr(8'h14, 8'h80);
      op({16'h0014, OPC_DEC_R}, 4, 8'h80, 8'h90);
      rc(ra(8'h14), 32'h7f);
      sr(8'h15, 8'h14);
      op({16'h0015, OPC_DEC_IR}, 4, 8'h10, 8'h00);
      rc(ra(8'h14), 32'h7e);
      sr(8'h16, 8'h01);
      op({16'h0016, OPC_DEC_R}, 4, 8'h00, 8'h40);
      op({16'h0016, OPC_DEC_R}, 4, 8'h00, 8'h20);
   endtask

   task automatic t_inc;
      sr(8'h1e, 8'h7f);
      op({16'h001e, OPC_INC_R}, 4, 8'h80, 8'hb0);
      rc(ra(8'h1e), 32'h80);
      sr(8'h1f, 8'h1e);
      op({16'h001f, OPC_INC_IR}, 4, 8'h10, 8'h20);
      rc(ra(8'h1e), 32'h81);
      sr(8'h03, 8'hff);
      op({16'h0000, 4'h3, OPC_INC_W_LO}, 4, 8'h80, 8'hc0);
      rc(ra(8'h03), 32'h00);
   endtask

   task automatic t_gie;
      int n0;
      wr(ADDR_SYM, 32'h04, RESP_OKAY);
      op({16'h0000, OPC_GIRQ_DIS}, 4, 8'hf0, 8'hf0);
      rc(ADDR_SYM, 32'h00);
      n0 = vq.size();
      irq_req_i <= 8'h28;
      @(posedge ref_clk_i);
      irq_req_i <= 8'h00;
      repeat (20) @(posedge ref_clk_i);
      rc(ADDR_PEND, 32'h28);
      chk(32'(vq.size() - n0), 32'h0);
      op({16'h0000, OPC_GIRQ_EN}, 4, 8'h50, 8'h50);
      rc(ADDR_SYM, 32'h04);
      repeat (8) @(posedge ref_clk_i);
      chk(32'(vq.size() - n0), 32'h2);
      chk(32'(vq[n0]), 32'h3);
      chk(32'(vq[n0 + 1]), 32'h5);
      rc(ADDR_PEND, 32'h00);
   endtask

   task automatic t_idle;
      logic [31:0] d;
      logic [1:0] r;
      op({16'h0000, OPC_IDLE}, 4, 8'h50, 8'h50);
      chk(32'(cpu_clk_en_o), 32'h0);
      wr(ADDR_FLAGS, 32'h0, RESP_SLVERR);
      wr(ra(8'h03), 32'h55, RESP_SLVERR);
      rc(ADDR_FLAGS, 32'h50);
      rc(ra(8'h03), 32'h00);
      rc(ADDR_STATUS, 32'h00230002);
      chk(32'(cpu_clk_en_o), 32'h0);
      irq_req_i <= 8'h01;
      @(posedge ref_clk_i);
      irq_req_i <= 8'h00;
      repeat (2) @(posedge ref_clk_i);
      chk(32'(cpu_clk_en_o), 32'h1);
      op({16'h0000, OPC_IDLE}, 4, 8'h50, 8'h50);
      reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      chk(32'(cpu_clk_en_o), 32'h1);
      rc(ADDR_FLAGS, 32'h00);
      rd(12'h020, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(12'h020, 32'h1, RESP_SLVERR);
      wr(ADDR_INSTR, 32'h000002, RESP_OKAY);
      rc(ADDR_STATUS, 32'h00000004);
   endtask

   initial begin
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      t_com();
      t_cmp();
      t_dec();
      t_inc();
      t_gie();
      t_idle();
      conclude();
   end

   // Whole sequence needs roughly four hundred cycles
   initial begin
      repeat (6000) @(posedge ref_clk_i);
      error_cnt++;
      conclude();
   end
endmodule // test_cpu_unary_compare_intctl_ops
